// ===== common/lfi_pkg.sv
// shared constants and types of the linear function interpolator
`default_nettype none
package lfi_pkg;
   // drum word layout
   localparam int WORD_W = 11;
   localparam int DATA_W = 10;
   localparam int FLAG_POS = 10;
   localparam int KIND_MSB = 9;
   localparam int KIND_LSB = 8;
   localparam int NVAR_MSB = 1;
   localparam int NVAR_LSB = 0;
   localparam logic [1:0] KIND_CTRL = 2'h0;
   localparam logic [1:0] KIND_VAR = 2'h1;
   localparam logic [1:0] KIND_STORE = 2'h2;
   localparam logic [1:0] KIND_BLANK = 2'h3;
   // segments and breakpoints
   localparam int N_SEG = 8;
   localparam int N_BRK = 9;
   localparam int SEL_W = 3;
   localparam int MAX_VARS = 3;
   localparam int N_CORNER = 8;
   localparam int N_STEP = 7;
   localparam logic [3:0] LAST_DIGIT = 4'h8;
   // arithmetic precision
   localparam int ORD_W = 10;
   localparam int ACC_W = 14;
   localparam int EXT_W = ACC_W - ORD_W;
   localparam int FRAC_W = ACC_W - SEL_W;
   localparam logic [ACC_W:0] ROUND_HALF = 15'h0008;
   localparam logic [ORD_W:0] ORD_MAX = 11'h03ff;
   // core memory word: sign then fraction
   localparam int CORE_W = 24;
   localparam int CORE_FRAC_MSB = 22;
   localparam int ADDR_W = 8;
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [2:0] {
      PH_WAIT_CTRL,
      PH_VARS,
      PH_ORDS,
      PH_CALC,
      PH_STORE
   } lfi_phase_e;

   typedef struct packed {
      logic flag;
      logic [DATA_W-1:0] data;
   } lfi_word_s;

   typedef struct packed {
      logic req;
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [CORE_W-1:0] wdata;
   } lfi_mem_s;

   typedef struct packed {
      logic [SEL_W-1:0] lo;
      logic [SEL_W-1:0] hi;
      logic [1:0] var_sel;
   } lfi_step_s;
endpackage : lfi_pkg
`default_nettype wire

// ===== hw/lfi_core.sv
// piecewise-linear function interpolator running from the drum word stream
//
// Overview of operation
// - variable range is eight equal segments, nine implicit breakpoints
// - bracketing pair picked by the three top fraction bits only
// - control word opens a function and gives one to three variables
// - address of each variable then 9, 81 or 729 ordinates from f(0) upward
// - core used only when main program makes no request
// - one core read tried per address word, retried on repeats
// - variable latched and bracketed before first ordinate arrives
// - only the two, four or eight bracketing corner ordinates are kept, others ignored
// - result held until store word, then written in free cycle
// - linear interpolation by own adder and registers
// - function blocks processed one after another as read
// - runs by itself, no main program instruction needed
// - drum word is control flag plus ten data bits
// - arithmetic to fourteen places, rounded to ten bits
`timescale 1ns/1ps
`default_nettype none
module lfi_core #(
   parameter int ADDR_BITS = 8,
   parameter int BUF_DEPTH = 8
) (
   // clock, reset, enable
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // drum word stream
   input wire logic drum_valid_in,
   output logic drum_ready_out,
   input wire lfi_pkg::lfi_word_s drum_word_in,
   // shared core memory
   input wire logic main_req_in,
   output lfi_pkg::lfi_mem_s mem_out,
   input wire logic [lfi_pkg::CORE_W-1:0] mem_rdata_in,
   // status
   output logic [lfi_pkg::ORD_W-1:0] result_out,
   output logic result_valid_out
);
   import lfi_pkg::*;

   typedef struct packed {
      lfi_phase_e phase;
      logic [1:0] nvars;
      logic [1:0] vidx;
      logic have_addr;
      logic fetched;
      logic [ADDR_BITS-1:0] last_addr;
      logic rd_pend;
      logic [MAX_VARS-1:0][SEL_W-1:0] sel;
      logic [MAX_VARS-1:0][FRAC_W-1:0] frac;
      logic [MAX_VARS-1:0][3:0] dig;
      logic [N_CORNER-1:0][ACC_W-1:0] ord;
      logic [2:0] step;
      logic [ORD_W-1:0] result;
      logic res_ok;
      logic stored;
   } lfi_state_s;

   lfi_state_s st;
   lfi_state_s next_st;

   logic [WORD_W-1:0] fifo_head;
   logic head_valid;
   logic head_ready;
   lfi_word_s head;
   logic [1:0] head_kind;
   logic [ADDR_BITS-1:0] head_addr;
   logic take;
   logic core_free;
   logic [2:0] steps_needed;
   lfi_step_s cur_step;
   logic [ACC_W-1:0] lerp_out;

   // ordered step table: two x pairs then their y pair, for each z plane, then z
   function automatic lfi_step_s step_of(input logic [2:0] s);
      lfi_step_s r;
      r = '0;
      unique case (s)
         3'h0: r = '{lo: 3'h0, hi: 3'h1, var_sel: 2'h0};
         3'h1: r = '{lo: 3'h2, hi: 3'h3, var_sel: 2'h0};
         3'h2: r = '{lo: 3'h0, hi: 3'h2, var_sel: 2'h1};
         3'h3: r = '{lo: 3'h4, hi: 3'h5, var_sel: 2'h0};
         3'h4: r = '{lo: 3'h6, hi: 3'h7, var_sel: 2'h0};
         3'h5: r = '{lo: 3'h4, hi: 3'h6, var_sel: 2'h1};
         3'h6: r = '{lo: 3'h0, hi: 3'h4, var_sel: 2'h2};
         default: r = '0;
      endcase
      return r;
   endfunction : step_of

   // does the ordinate at the current digits belong to corner c
   function automatic logic corner_hit(input logic [MAX_VARS-1:0][3:0] dig,
                                       input logic [MAX_VARS-1:0][SEL_W-1:0] sel,
                                       input logic [1:0] nvars,
                                       input logic [2:0] c);
      logic hit;
      hit = 1'b1;
      for (int v = 0; v < MAX_VARS; v++) begin
         if (v < int'(nvars)) begin
            if (dig[v] != ({1'b0, sel[v]} + {3'h0, c[v]})) begin
               hit = 1'b0;
            end
         end else if (c[v] || dig[v] != 4'h0) begin
            hit = 1'b0;
         end
      end
      return hit;
   endfunction : corner_hit

   // one linear step: a + (b - a) * 8 * offset, fourteen places
   function automatic logic [ACC_W-1:0] lerp(input logic [ACC_W-1:0] a,
                                             input logic [ACC_W-1:0] b,
                                             input logic [FRAC_W-1:0] t);
      logic signed [ACC_W:0] diff;
      logic signed [ACC_W+FRAC_W+1:0] prod;
      logic signed [ACC_W+FRAC_W+1:0] sum;
      diff = $signed({1'b0, b}) - $signed({1'b0, a});
      prod = diff * $signed({1'b0, t});
      sum = $signed({{(FRAC_W+2){1'b0}}, a}) + (prod >>> FRAC_W);
      return sum[ACC_W-1:0];
   endfunction : lerp

   // the buffer absorbs drum words while the core waits for a read or calculates
   lfi_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(BUF_DEPTH)
   ) u_fifo (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .in_valid_in(drum_valid_in),
      .in_ready_out(drum_ready_out),
      .in_data_in(drum_word_in),
      .out_valid_out(head_valid),
      .out_ready_in(head_ready),
      .out_data_out(fifo_head)
   );

   assign head = lfi_word_s'(fifo_head);
   assign head_kind = head.data[KIND_MSB:KIND_LSB];
   assign head_addr = head.data[ADDR_BITS-1:0];
   // stall while a read returns or the adder is busy
   assign head_ready = !st.rd_pend && (st.phase != PH_CALC);
   assign take = ce_in && head_valid && head_ready;
   assign core_free = !main_req_in;
   assign steps_needed = 3'((4'h1 << st.nvars) - 4'h1);
   assign cur_step = step_of(st.step);
   assign lerp_out = lerp(st.ord[cur_step.lo], st.ord[cur_step.hi],
                          st.frac[cur_step.var_sel]);

   always_comb begin
      logic [ACC_W:0] rounded;
      logic last;
      rounded = '0;
      last = 1'b0;
      next_st = st;
      mem_out = '0;
      mem_out.addr = head_addr;
      mem_out.wdata = {1'b0, st.result, {(CORE_W-1-ORD_W){1'b0}}};

      // variable latched the cycle after its read was granted
      if (st.rd_pend) begin
         next_st.rd_pend = 1'b0;
         next_st.fetched = 1'b1;
         next_st.sel[st.vidx] = mem_rdata_in[CORE_FRAC_MSB -: SEL_W];
         next_st.frac[st.vidx] = mem_rdata_in[CORE_FRAC_MSB-SEL_W -: FRAC_W];
      end

      if (st.phase == PH_CALC) begin
         next_st.ord[cur_step.lo] = lerp_out;
         next_st.step = st.step + 3'h1;
         if (st.step + 3'h1 == steps_needed) begin
            rounded = {1'b0, lerp_out} + ROUND_HALF;
            next_st.result = (rounded[ACC_W:EXT_W] > ORD_MAX) ?
                             ORD_MAX[ORD_W-1:0] : rounded[ACC_W-1:EXT_W];
            next_st.res_ok = 1'b1;
            next_st.phase = PH_STORE;
         end
      end

      if (take) begin
         if (head.flag && head_kind == KIND_CTRL) begin
            next_st.phase = PH_VARS;
            next_st.nvars = (head.data[NVAR_MSB:NVAR_LSB] == 2'h0) ?
                            2'h1 : head.data[NVAR_MSB:NVAR_LSB];
            next_st.vidx = '0;
            next_st.have_addr = 1'b0;
            next_st.fetched = 1'b0;
            next_st.dig = '0;
            next_st.ord = '0;
            next_st.step = '0;
            next_st.res_ok = 1'b0;
            next_st.stored = 1'b0;
         end else if (head.flag && head_kind == KIND_VAR && st.phase == PH_VARS) begin
            // a new address after a fetched one moves to the next variable
            if (st.have_addr && st.fetched && head_addr != st.last_addr) begin
               if (st.vidx + 2'h1 < st.nvars) begin
                  next_st.vidx = st.vidx + 2'h1;
                  next_st.fetched = 1'b0;
                  next_st.last_addr = head_addr;
                  if (core_free) begin
                     mem_out.req = 1'b1;
                     next_st.rd_pend = 1'b1;
                  end
               end
            end else if (!st.fetched) begin
               next_st.have_addr = 1'b1;
               next_st.last_addr = head_addr;
               if (core_free) begin
                  mem_out.req = 1'b1;
                  next_st.rd_pend = 1'b1;
               end
            end
         end else if (!head.flag && (st.phase == PH_VARS || st.phase == PH_ORDS)) begin
            next_st.phase = PH_ORDS;
            for (int c = 0; c < N_CORNER; c++) begin
               if (corner_hit(st.dig, st.sel, st.nvars, 3'(c))) begin
                  next_st.ord[c] = {head.data, {EXT_W{1'b0}}};
               end
            end
            last = 1'b1;
            for (int v = 0; v < MAX_VARS; v++) begin
               if (v < int'(st.nvars) && st.dig[v] != LAST_DIGIT) begin
                  last = 1'b0;
               end
            end
            // odometer of digits, x fastest
            next_st.dig = st.dig;
            for (int v = 0; v < MAX_VARS; v++) begin
               if (st.dig[v] == LAST_DIGIT) begin
                  next_st.dig[v] = 4'h0;
               end else begin
                  next_st.dig[v] = st.dig[v] + 4'h1;
                  break;
               end
            end
            if (last) begin
               next_st.phase = PH_CALC;
               next_st.step = '0;
            end
         end else if (head.flag && head_kind == KIND_STORE) begin
            if (st.res_ok && !st.stored && core_free) begin
               mem_out.req = 1'b1;
               mem_out.we = 1'b1;
               next_st.stored = 1'b1;
            end
         end
         // blanks and stray words only give the adder time
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st <= '0;
      end else if (ce_in) begin
         st <= next_st;
      end
   end

   assign result_out = st.result;
   assign result_valid_out = st.res_ok;
endmodule : lfi_core
`default_nettype wire

// ===== hw/lfi_fifo.sv
// word fifo between the drum reader and the interpolator core
`timescale 1ns/1ps
`default_nettype none
module lfi_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int PTR_W = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] rd;
      logic [PTR_W-1:0] wr;
      logic [PTR_W:0] count;
   } lfi_fifo_state_s;

   lfi_fifo_state_s st;
   lfi_fifo_state_s next_st;
   logic push;
   logic pop;

   assign in_ready_out = (st.count != (PTR_W+1)'(DEPTH));
   assign out_valid_out = (st.count != '0);
   assign out_data_out = st.mem[st.rd];
   assign push = ce_in && in_valid_in && in_ready_out;
   assign pop = ce_in && out_ready_in && out_valid_out;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = in_data_in;
         next_st.wr = (st.wr == PTR_W'(DEPTH-1)) ? '0 : st.wr + 1'b1;
      end
      if (pop) begin
         next_st.rd = (st.rd == PTR_W'(DEPTH-1)) ? '0 : st.rd + 1'b1;
      end
      if (push && !pop) begin
         next_st.count = st.count + 1'b1;
      end else if (pop && !push) begin
         next_st.count = st.count - 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st <= '0;
      end else if (ce_in) begin
         st <= next_st;
      end
   end
endmodule : lfi_fifo
`default_nettype wire

// ===== tb/lfi_chk.sv
// port assertions for the interpolator core
`timescale 1ns/1ps
`default_nettype none
module lfi_chk (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // drum stream
   input wire logic drum_valid_in,
   input wire logic drum_ready_out,
   input wire lfi_pkg::lfi_word_s drum_word_in,
   // shared core
   input wire logic main_req_in,
   input wire lfi_pkg::lfi_mem_s mem_out,
   input wire logic [lfi_pkg::CORE_W-1:0] mem_rdata_in,
   // status
   input wire logic [lfi_pkg::ORD_W-1:0] result_out,
   input wire logic result_valid_out
);
   import lfi_pkg::*;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   property p_prio;
      mem_out.req |-> !main_req_in;
   endproperty
   a_prio: assert property (p_prio)
      else $error("core request while main program busy");
   property p_pulse;
      mem_out.req |=> !mem_out.req;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("core request longer than one cycle");
   property p_wr_valid;
      mem_out.req && mem_out.we |-> result_valid_out;
   endproperty
   a_wr_valid: assert property (p_wr_valid)
      else $error("write without a computed result");
   property p_wr_data;
      mem_out.req && mem_out.we |-> mem_out.wdata == {1'b0, result_out, 13'h0000};
   endproperty
   a_wr_data: assert property (p_wr_data)
      else $error("write data differs from held result");
   property p_ce;
      !ce_in |-> !mem_out.req;
   endproperty
   a_ce: assert property (p_ce)
      else $error("core request while disabled");
   property p_freeze;
      !ce_in |=> $stable(result_out) && $stable(result_valid_out);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("result moved while disabled");
   property p_rst;
      $fell(rst_in) |-> !mem_out.req && !result_valid_out && drum_ready_out
         && result_out == 10'h000;
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not cleared by reset");
   property p_hold;
      result_valid_out && $past(result_valid_out) |-> $stable(result_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("held result changed");
endmodule : lfi_chk
`default_nettype wire

// ===== tb/lfi_mem.sv
// core memory with a main program that always wins
`timescale 1ns/1ps
`default_nettype none
module lfi_mem (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // busy slots out of every four
   input wire logic [1:0] busy_in,
   // core port
   input wire lfi_pkg::lfi_mem_s mem_in,
   output logic main_req_out,
   output logic [lfi_pkg::CORE_W-1:0] rdata_out
);
   import lfi_pkg::*;
   logic [CORE_W-1:0] core [256];
   logic [1:0] slot;
   initial begin
      slot = 2'h0;
      main_req_out = 1'b0;
      rdata_out = 24'h00_0000;
   end
   always @(posedge sys_clk_in) begin
      slot <= rst_in ? 2'h0 : slot + 2'h1;
      // at most three busy slots, so five repeats always meet a hole
      main_req_out <= !rst_in && (slot < busy_in);
      if (mem_in.req && mem_in.we) begin
         core[mem_in.addr] <= mem_in.wdata;
      end
      // read data valid one cycle only, scrambled afterwards
      rdata_out <= (mem_in.req && !mem_in.we) ? core[mem_in.addr] : ~rdata_out;
   end
endmodule : lfi_mem
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the interpolator core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin failures++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module testbench;
   import lfi_pkg::*;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic ce_in = 1'b1;
   logic drum_valid_in = 1'b0;
   lfi_word_s drum_word_in = '0;
   logic main_req_in, drum_ready_out, result_valid_out;
   lfi_mem_s mem_out;
   logic [CORE_W-1:0] mem_rdata_in;
   logic [ORD_W-1:0] result_out;
   logic [1:0] busy = 2'h0;
   int failures = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [7:0] exp_a[$];
   logic [9:0] exp_v[$];
   logic [7:0] ea;
   logic [9:0] ev;

   always #5 sys_clk_in = ~sys_clk_in;

   lfi_core u_lfi_core (.sys_clk_in, .rst_in, .ce_in, .drum_valid_in, .drum_ready_out,
      .drum_word_in, .main_req_in, .mem_out, .mem_rdata_in, .result_out, .result_valid_out);
   lfi_mem u_lfi_mem (.sys_clk_in, .rst_in, .busy_in(busy), .mem_in(mem_out),
      .main_req_out(main_req_in), .rdata_out(mem_rdata_in));

   task final_report;
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 4000) begin
         failures++;
         final_report();
      end
   end

   // word held until an edge that takes it; enable toggled only where asked
   task put(input logic f, input logic [9:0] d, input logic rnd);
      logic ok;
      drum_valid_in <= 1'b1;
      drum_word_in <= '{flag: f, data: d};
      do begin
         ce_in <= !rnd || ($urandom % 4 != 0);
         @(negedge sys_clk_in);
         ok = drum_ready_out === 1'b1 && ce_in === 1'b1;
         @(posedge sys_clk_in);
      end while (!ok);
   endtask : put

   // one single-variable block; ordinates ascend so the slope is never negative
   task block(input int i);
      logic [9:0] o [9];
      logic [CORE_W-1:0] x;
      logic [13:0] a, d;
      int s;
      x = (i == 0) ? 24'h00_0000 : (i == 1) ? 24'h7f_ffff : {1'b0, 23'($urandom)};
      o[0] = 10'($urandom % 100);
      for (int k = 1; k < 9; k++) begin
         o[k] = o[k-1] + 10'($urandom % 115);
      end
      u_lfi_mem.core[8'(2 * i)] = x;
      s = x[22:20];
      a = {o[s], 4'h0};
      d = {o[s+1] - o[s], 4'h0};
      exp_a.push_back(8'h80 + 8'(i));
      exp_v.push_back(10'((a + ((d * x[19:9]) >> 11) + 8) >> 4));
      busy <= 2'(i);
      put(1'b1, 10'h001, 1'b0);
      repeat (5) put(1'b1, {2'h1, 8'(2 * i)}, 1'b0);
      for (int k = 0; k < 9; k++) begin
         put(1'b0, o[k], i % 4 == 0 && k > 3);
      end
      repeat (2) put(1'b1, 10'h300, 1'b0);
      repeat (5) put(1'b1, {2'h2, 8'h80 + 8'(i)}, 1'b0);
   endtask : block

   // one interpolation step on fourteen-place values, floor like the adder
   function automatic int ip(input int a, input int b, input int t);
      return a + (((b - a) * t) >>> 11);
   endfunction : ip

   // two-variable block: nine sheets of nine ordinates, x fastest
   task block2(input int i);
      int f [81];
      int xs, xt, ys, yt, p, q, r;
      logic [CORE_W-1:0] x, y;
      x = {1'b0, 23'($urandom)};
      y = {1'b0, 23'($urandom)};
      u_lfi_mem.core[8'(40 + 2 * i)] = x;
      u_lfi_mem.core[8'(41 + 2 * i)] = y;
      xs = x[22:20];
      xt = x[19:9];
      ys = y[22:20];
      yt = y[19:9];
      for (int k = 0; k < 81; k++) begin
         f[k] = $urandom % 1024;
      end
      p = ip(f[ys * 9 + xs] * 16, f[ys * 9 + xs + 1] * 16, xt);
      q = ip(f[ys * 9 + 9 + xs] * 16, f[ys * 9 + 10 + xs] * 16, xt);
      r = ip(p, q, yt);
      exp_a.push_back(8'ha0 + 8'(i));
      exp_v.push_back(10'((r + 8) >> 4));
      busy <= 2'h3;
      put(1'b1, 10'h002, 1'b0);
      repeat (5) put(1'b1, {2'h1, 8'(40 + 2 * i)}, 1'b0);
      repeat (5) put(1'b1, {2'h1, 8'(41 + 2 * i)}, 1'b0);
      for (int k = 0; k < 81; k++) begin
         put(1'b0, 10'(f[k]), 1'b0);
      end
      repeat (4) put(1'b1, 10'h300, 1'b0);
      repeat (5) put(1'b1, {2'h2, 8'ha0 + 8'(i)}, 1'b0);
   endtask : block2

   // every write is matched against the oldest note
   always @(negedge sys_clk_in) begin
      if (!rst_in && mem_out.req === 1'b1 && mem_out.we === 1'b1) begin
         if (exp_a.size() == 0) begin
            failures++;
            $display("unexpected write expected none seen %h", mem_out.addr);
         end else begin
            ea = exp_a.pop_front();
            ev = exp_v.pop_front();
            `CHK("store address", ea, mem_out.addr)
            `CHK("stored value", ev, mem_out.wdata[22:13])
            `CHK("result", ev, result_out)
         end
      end
   end

   initial begin
      void'($urandom(68377));
      repeat (8) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      @(posedge sys_clk_in);
      for (int i = 0; i < 12; i++) begin
         block(i);
      end
      for (int i = 0; i < 3; i++) begin
         block2(i);
      end
      drum_valid_in <= 1'b0;
      ce_in <= 1'b1;
      for (int w = 0; w < 300 && exp_a.size() > 0; w++) begin
         @(posedge sys_clk_in);
      end
      `CHK("pending stores", 0, exp_a.size())
      final_report();
   end
endmodule : testbench

bind lfi_core lfi_chk u_lfi_chk (.sys_clk_in, .rst_in, .ce_in, .drum_valid_in, .drum_ready_out,
   .drum_word_in, .main_req_in, .mem_out, .mem_rdata_in, .result_out, .result_valid_out);
`default_nettype wire
